//--- logic/sub_trap_core.sv
// execution core for byte/word subtract, software trap and A-to-B copy
// assumes memory answers a read in the same clock (rdata valid each cycle)
// and that every other opcode is handled elsewhere: here it is a 2-cycle no-op
////////////////////////////////////////////////////////////////////////////////
module sub_trap_core
  import sub_trap_pkg::*;
(
  input  wire logic        core_clk_i,   // cpu clock, 40 MHz
  input  wire logic        nrst_i,       // async reset, active low
  input  wire logic        ce_i,         // clock enable, freezes state
  input  wire logic [7:0]  rdata_i,      // memory read data
  output logic      [15:0] addr_o,       // bus address
  output logic      [7:0]  wdata_o,      // write data
  output logic             rw_o,         // 1 read, 0 write
  output logic      [7:0]  acc_a_o,      // accumulator a
  output logic      [7:0]  acc_b_o,      // accumulator b
  output logic      [7:0]  ccr_o,        // condition codes
  output logic      [15:0] sp_o,         // stack pointer
  output logic      [15:0] pc_o          // program counter
);
  typedef enum logic [8:0] {
    S_FETCH = 9'h001, S_OP2  = 9'h002, S_ADR   = 9'h004,
    S_IDXD  = 9'h008, S_RDH  = 9'h010, S_RDL   = 9'h020,
    S_FIN   = 9'h040, S_STK  = 9'h080, S_VEC   = 9'h100
  } state_t;
  typedef enum logic [1:0] {M_IMM, M_DIR, M_EXT, M_IDX} mode_t;

  state_t      state;
  mode_t       mode;
  logic        is_word, to_b, use_y, prefixed, vec_lo;
  logic [3:0]  stk_cnt;
  logic [15:0] ea, opnd, idx_x, idx_y;
  logic [7:0]  acc_a, acc_b, condition_code_register, opc;
  logic [15:0] sp, pc;

  // subtract opcodes have low nibble 0 (byte) or 3 (word) and select mode by bits 5:4
  function automatic logic is_sub(input logic [7:0] op);
    is_sub = (op[3:0] == 4'h0 || op[3:0] == 4'h3) && op[7]
             && !(op[6] && op[3:0] == 4'h3);
  endfunction
  function automatic mode_t mode_of(input logic [7:0] op);
    case (op[5:4])
      2'b00:   mode_of = M_IMM;
      2'b01:   mode_of = M_DIR;
      2'b11:   mode_of = M_EXT;
      default: mode_of = M_IDX;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] d_res;
  logic        d_n, d_z, d_v, d_c;
  logic [7:0]  b_res;
  logic        b_n, b_z, b_v, b_c;

  sub_alu #(.W(16)) u_word (
    .acc_i    ({acc_a, acc_b}),
    .opnd_i   (opnd),
    .res_o    (d_res),
    .neg_o    (d_n),
    .zero_o   (d_z),
    .ovf_o    (d_v),
    .borrow_o (d_c)
  );
  sub_alu #(.W(8)) u_byte (
    .acc_i    (to_b ? acc_b : acc_a),
    .opnd_i   (opnd[7:0]),
    .res_o    (b_res),
    .neg_o    (b_n),
    .zero_o   (b_z),
    .ovf_o    (b_v),
    .borrow_o (b_c)
  );

  // stacked byte for slot k of the trap sequence
  function automatic logic [7:0] stk_byte(input logic [3:0] k,
    input logic [15:0] p, input logic [15:0] y, input logic [15:0] x,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    case (k)
      4'h0:    stk_byte = p[7:0];
      4'h1:    stk_byte = p[15:8];
      4'h2:    stk_byte = y[7:0];
      4'h3:    stk_byte = y[15:8];
      4'h4:    stk_byte = x[7:0];
      4'h5:    stk_byte = x[15:8];
      4'h6:    stk_byte = a;
      4'h7:    stk_byte = b;
      default: stk_byte = c;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // index registers are held constant here; their loads live elsewhere
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      idx_x <= 16'h0000;
      idx_y <= 16'h0000;
    end
    else if (ce_i)
    begin
      idx_x <= idx_x;
      idx_y <= idx_y;
    end
  end

  // sequencer: bus address, direction, pc, sp
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state    <= S_FETCH;
      mode     <= M_IMM;
      is_word  <= 1'b0;
      to_b     <= 1'b0;
      use_y    <= 1'b0;
      prefixed <= 1'b0;
      vec_lo   <= 1'b0;
      stk_cnt  <= 4'h0;
      ea       <= 16'h0000;
      opnd     <= 16'h0000;
      opc      <= 8'h00;
      pc       <= PC_RESET;
      sp       <= SP_RESET;
      addr_o   <= PC_RESET;
      wdata_o  <= 8'h00;
      rw_o     <= 1'b1;
    end
    else if (ce_i)
    begin
      case (state)
        S_FETCH:
        begin
          pc <= pc + 16'h0001;
          addr_o <= pc + 16'h0001;
          if (rdata_i == OP_PREFIX_Y && !prefixed)
          begin
            prefixed <= 1'b1;
            use_y    <= 1'b1;
          end
          else
          begin
            opc      <= rdata_i;
            prefixed <= 1'b0;
            state    <= S_OP2;
            mode     <= mode_of(rdata_i);
            is_word  <= rdata_i[1];
            to_b     <= rdata_i[6];
            if (!prefixed)
              use_y <= 1'b0;
          end
        end
        S_OP2:
        begin
          if (opc == OP_TRAP)
          begin
            // mask bit is never consulted: the trap always runs
            pc      <= pc;
            addr_o  <= sp;
            rw_o    <= 1'b0;
            wdata_o <= pc[7:0];
            stk_cnt <= 4'h0;
            state   <= S_STK;
          end
          else if (!is_sub(opc))
          begin
            addr_o <= pc;
            state  <= S_FETCH;
            if (opc == OP_TAB)
              addr_o <= pc;
          end
          else
          begin
            pc <= pc + 16'h0001;
            case (mode)
              M_IMM:
              begin
                opnd <= is_word ? {rdata_i, 8'h00} : {8'h00, rdata_i};
                if (is_word)
                begin
                  addr_o <= pc + 16'h0001;
                  state  <= S_RDL;
                  ea     <= pc;
                end
                else
                begin
                  addr_o <= pc + 16'h0001;
                  state  <= S_FIN;
                end
              end
              M_DIR:
              begin
                ea     <= {8'h00, rdata_i};
                addr_o <= {8'h00, rdata_i};
                state  <= S_RDH;
              end
              M_EXT:
              begin
                ea[15:8] <= rdata_i;
                addr_o   <= pc + 16'h0001;
                state    <= S_ADR;
              end
              default:
              begin
                ea     <= (use_y ? idx_y : idx_x) + {8'h00, rdata_i};
                addr_o <= DUMMY_ADDR;
                state  <= S_IDXD;
              end
            endcase
          end
        end
        S_ADR:
        begin
          pc     <= pc + 16'h0001;
          ea     <= {ea[15:8], rdata_i};
          addr_o <= {ea[15:8], rdata_i};
          state  <= S_RDH;
        end
        S_IDXD:
        begin
          addr_o <= ea;
          state  <= S_RDH;
        end
        S_RDH:
        begin
          if (is_word)
          begin
            opnd[15:8] <= rdata_i;
            addr_o     <= ea + 16'h0001;
            state      <= S_RDL;
          end
          else
          begin
            opnd   <= {8'h00, rdata_i};
            addr_o <= pc;
            state  <= S_FIN;
          end
        end
        S_RDL:
        begin
          opnd[7:0] <= rdata_i;
          if (mode == M_IMM)
            pc <= pc + 16'h0001;
          addr_o <= DUMMY_ADDR;
          state  <= S_FIN;
        end
        S_FIN:
        begin
          addr_o <= pc;
          state  <= S_FETCH;
        end
        S_STK:
        begin
          sp      <= sp - 16'h0001;
          stk_cnt <= stk_cnt + 4'h1;
          if (stk_cnt == STACK_BYTES - 4'h1)
          begin
            // re-read of the last slot, then the vector
            rw_o   <= 1'b1;
            addr_o <= addr_o;
            state  <= S_VEC;
            vec_lo <= 1'b0;
          end
          else
          begin
            addr_o  <= sp - 16'h0001;
            wdata_o <= stk_byte(stk_cnt + 4'h1, pc, idx_y, idx_x,
                                acc_a, acc_b, condition_code_register);
          end
        end
        S_VEC:
        begin
          if (addr_o == TRAP_VECTOR)
          begin
            pc[15:8] <= rdata_i;
            addr_o   <= TRAP_VECTOR + 16'h0001;
            vec_lo   <= 1'b1;
          end
          else if (vec_lo)
          begin
            pc     <= {pc[15:8], rdata_i};
            addr_o <= {pc[15:8], rdata_i};
            vec_lo <= 1'b0;
            state  <= S_FETCH;
          end
          else
            addr_o <= TRAP_VECTOR;
        end
        default:
          state <= S_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulators and condition codes are written at the end of each subtract or copy; the trap sets only the mask, on its last stack write
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_a <= 8'h00;
      acc_b <= 8'h00;
      condition_code_register   <= CC_RESET;
    end
    else if (ce_i)
    begin
      if (state == S_FIN && is_sub(opc))
      begin
        if (is_word)
        begin
          {acc_a, acc_b} <= d_res;
          condition_code_register[CC_N] <= d_n;
          condition_code_register[CC_Z] <= d_z;
          condition_code_register[CC_V] <= d_v;
          condition_code_register[CC_C] <= d_c;
        end
        else
        begin
          if (to_b)
            acc_b <= b_res;
          else
            acc_a <= b_res;
          condition_code_register[CC_N] <= b_n;
          condition_code_register[CC_Z] <= b_z;
          condition_code_register[CC_V] <= b_v;
          condition_code_register[CC_C] <= b_c;
        end
      end
      else if (state == S_OP2 && opc == OP_TAB)
      begin
        acc_b     <= acc_a;
        condition_code_register[CC_N] <= acc_a[7];
        condition_code_register[CC_Z] <= (acc_a == 8'h00);
        condition_code_register[CC_V] <= 1'b0;
      end
      else if (state == S_STK && stk_cnt == STACK_BYTES - 4'h1)
        condition_code_register[CC_I] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      acc_a_o <= 8'h00;
      acc_b_o <= 8'h00;
      ccr_o   <= CC_RESET;
      sp_o    <= SP_RESET;
      pc_o    <= PC_RESET;
    end
    else if (ce_i)
    begin
      acc_a_o <= acc_a;
      acc_b_o <= acc_b;
      ccr_o   <= condition_code_register;
      sp_o    <= sp;
      pc_o    <= pc;
    end
  end
endmodule

//--- logic/sub_trap_pkg.sv
// shared constants for the subtract / trap / transfer execution core
// assumes a byte-wide synchronous memory bus, one bus cycle per clock
package sub_trap_pkg;
  localparam logic [7:0]  OP_SUBTRACT_FROM_A_IMM  = 8'h80;
  localparam logic [7:0]  OP_SUBTRACT_FROM_A_DIR  = 8'h90;
  localparam logic [7:0]  OP_SUBTRACT_FROM_A_EXT  = 8'hB0;
  localparam logic [7:0]  OP_SUBTRACT_FROM_A_IDX  = 8'hA0;
  localparam logic [7:0]  OP_SUBTRACT_FROM_B_IMM  = 8'hC0;
  localparam logic [7:0]  OP_SUBTRACT_FROM_B_DIR  = 8'hD0;
  localparam logic [7:0]  OP_SUBTRACT_FROM_B_EXT  = 8'hF0;
  localparam logic [7:0]  OP_SUBTRACT_FROM_B_IDX  = 8'hE0;
  localparam logic [7:0]  OP_SUBTRACT_SIXTEEN_BIT_IMM  = 8'h83;
  localparam logic [7:0]  OP_SUBTRACT_SIXTEEN_BIT_DIR  = 8'h93;
  localparam logic [7:0]  OP_SUBTRACT_SIXTEEN_BIT_EXT  = 8'hB3;
  localparam logic [7:0]  OP_SUBTRACT_SIXTEEN_BIT_IDX  = 8'hA3;
  localparam logic [7:0]  OP_PREFIX_Y  = 8'h18;
  localparam logic [7:0]  OP_TRAP      = 8'h3F;
  localparam logic [7:0]  OP_TAB       = 8'h16;
  localparam logic [15:0] DUMMY_ADDR   = 16'hFFFF;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [15:0] SP_RESET     = 16'h00FF;
  localparam logic [15:0] TRAP_VECTOR  = 16'hFFF6;
  localparam logic [7:0]  CC_RESET     = 8'hD0;
  // condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam int CC_I = 4;
  localparam logic [3:0]  STACK_BYTES  = 4'h9;
endpackage

//--- logic/sub_alu.sv
// subtract unit with borrow and overflow flags, byte or word width
// assumes flags are captured by the caller
module sub_alu
  import sub_trap_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic [W-1:0] acc_i,     // minuend
  input  wire logic [W-1:0] opnd_i,    // subtrahend
  output logic      [W-1:0] res_o,     // difference
  output logic              neg_o,     // result msb
  output logic              zero_o,    // result all zero
  output logic              ovf_o,     // signed overflow
  output logic              borrow_o   // unsigned borrow
);
  logic x, m, r;
  always_comb
  begin
    res_o    = acc_i - opnd_i;
    x        = acc_i[W-1];
    m        = opnd_i[W-1];
    r        = res_o[W-1];
    neg_o    = r;
    zero_o   = (res_o == '0);
    ovf_o    = (x & ~m & ~r) | (~x & m & r);
    borrow_o = (~x & m) | (m & r) | (r & ~x);
  end
endmodule

//--- verification/sub_trap_core_assertions.sv
// timing checks on the execution core's bus and register ports
// assumes one bus cycle per clock and the trap as the only writer
module sub_trap_core_assertions
  import sub_trap_pkg::*;
(
  input wire logic        core_clk_i, // cpu clock
  input wire logic        nrst_i,     // async reset, active low
  input wire logic        ce_i,       // clock enable
  input wire logic [7:0]  rdata_i,    // memory read data
  input wire logic [15:0] addr_o,     // bus address
  input wire logic [7:0]  wdata_o,    // write data
  input wire logic        rw_o,       // 1 read, 0 write
  input wire logic [7:0]  acc_a_o,    // accumulator a
  input wire logic [7:0]  acc_b_o,    // accumulator b
  input wire logic [7:0]  ccr_o,      // condition codes
  input wire logic [15:0] sp_o,       // stack pointer
  input wire logic [15:0] pc_o        // program counter
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_stack_nine_writes: assert property (
    $fell(rw_o) |=> !rw_o [*8] ##1 rw_o)
    else $error("stack write run is not nine bytes");
  a_stack_addr_down: assert property (
    !rw_o && !$past(rw_o) |-> addr_o == $past(addr_o) - 16'h0001)
    else $error("stack address did not step down by one");
  a_first_write_sp: assert property (
    $fell(rw_o) |-> addr_o == sp_o)
    else $error("first stacked byte not at the stack pointer");
  a_sp_drops_nine: assert property (
    $fell(rw_o) |-> ##10 sp_o == $past(sp_o, 10) - 16'h0009)
    else $error("stack pointer did not drop by nine");
  a_reread_last: assert property (
    $rose(rw_o) |-> addr_o == $past(addr_o))
    else $error("last stacked address not read again");
  a_vector_fetch: assert property (
    $rose(rw_o) |=> addr_o == TRAP_VECTOR
      ##1 addr_o == TRAP_VECTOR + 16'h0001)
    else $error("vector bytes not fetched after stacking");
  a_mask_after_trap: assert property (
    $rose(rw_o) |-> ##3 ccr_o[CC_I])
    else $error("interrupt mask clear after trap");
  a_dummy_is_read: assert property (
    addr_o == DUMMY_ADDR |-> rw_o)
    else $error("dummy address used for a write");
  a_freeze_holds: assert property (
    !ce_i |=> $stable(addr_o) && $stable(pc_o) && $stable(acc_b_o))
    else $error("state moved while the clock enable was low");
endmodule

bind sub_trap_core sub_trap_core_assertions sub_trap_core_assertions_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .rdata_i(rdata_i), .addr_o(addr_o), .wdata_o(wdata_o), .rw_o(rw_o),
  .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .ccr_o(ccr_o), .sp_o(sp_o),
  .pc_o(pc_o));

//--- verification/trap_memory_model.sv
// program and data memory answering reads within the bus cycle
// assumes the bench preloads the array while the core is in reset
module trap_memory_model
(
  input  wire logic        core_clk_i, // cpu clock
  input  wire logic        ce_i,       // bus cycle enable
  input  wire logic [15:0] addr_i,     // bus address
  input  wire logic [7:0]  wdata_i,    // write data
  input  wire logic        rw_i,       // 1 read, 0 write
  output logic      [7:0]  rdata_o     // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_rd = 8'h00;
  // plain always so the bench may also preload the array
  always @(posedge core_clk_i)
  begin
    if (ce_i && !rw_i)
      mem[addr_i] <= wdata_i;
    if (ce_i && rw_i)
      last_rd <= mem[addr_i];
  end
  // data lines released during writes: never show the last byte again
  assign rdata_o = rw_i ? mem[addr_i] : ~last_rd;
endmodule

//--- verification/subtract_swi_transfer_exec_test.sv
// self-checking bench for the subtract, trap and copy execution core
// assumes index registers stay zero, so indexed operands sit at their offset byte, 60 or 70
module subtract_swi_transfer_exec_test
  import sub_trap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OFS [0:4] = '{8'h00, 8'h10, 8'h30, 8'h20, 8'h20};
  localparam logic [7:0] CORNER [0:3] = '{8'h00, 8'h80, 8'h7F, 8'hFF};
  logic        core_clk_i = 1'b0;
  logic        nrst_i;
  logic        ce_i;
  logic [7:0]  rdata_i;
  logic [15:0] addr_o;
  logic [7:0]  wdata_o;
  logic        rw_o;
  logic [7:0]  acc_a_o;
  logic [7:0]  acc_b_o;
  logic [7:0]  ccr_o;
  logic [15:0] sp_o;
  logic [15:0] pc_o;
  logic [15:0] pc_w;
  logic [7:0]  exp_a;
  logic [7:0]  exp_b;
  logic [7:0]  exp_cc;
  int          error_cnt;
  int          checks_done;

  sub_trap_core sub_trap_core_inst (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .rdata_i(rdata_i), .addr_o(addr_o),
    .wdata_o(wdata_o), .rw_o(rw_o), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
    .ccr_o(ccr_o), .sp_o(sp_o), .pc_o(pc_o));
  trap_memory_model trap_memory_model_inst (.core_clk_i(core_clk_i),
    .ce_i(ce_i), .addr_i(addr_o), .wdata_i(wdata_o), .rw_i(rw_o),
    .rdata_o(rdata_i));

  initial
    forever #12.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [23:0] sub_calc(input logic [15:0] x,
    input logic [15:0] m, input logic wide, input logic [7:0] cc);
    logic [15:0] r;
    logic        xh;
    logic        mh;
    logic        rh;
    r = wide ? x - m : 16'(x[7:0] - m[7:0]);
    xh = wide ? x[15] : x[7];
    mh = wide ? m[15] : m[7];
    rh = wide ? r[15] : r[7];
    cc[CC_N] = rh;
    cc[CC_Z] = (r == 16'h0000);
    cc[CC_V] = xh & ~mh & ~rh | ~xh & mh & rh;
    cc[CC_C] = ~xh & mh | mh & rh | rh & ~xh;
    return {r, cc};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic put(input logic [7:0] b);
    trap_memory_model_inst.mem[pc_w] = b;
    pc_w = pc_w + 16'h0001;
  endtask

  // holds reset for 16 cycles; the program is loaded before release
  task automatic start_case();
    nrst_i = 1'b0;
    for (int a = 0; a < 65536; a++)
      trap_memory_model_inst.mem[a] = 8'h01;
    pc_w = 16'h0000;
    exp_a = 8'h00;
    exp_b = 8'h00;
    exp_cc = CC_RESET;
    repeat (16) @(negedge core_clk_i);
  endtask

  task automatic go(input int n);
    nrst_i = 1'b1;
    repeat (n) @(negedge core_clk_i);
  endtask

  // places one subtract in memory and updates the expected state
  task automatic emit(input logic [7:0] base, input int mode,
    input logic [15:0] val);
    logic [15:0] ea;
    logic [23:0] r;
    logic        wide;
    wide = (base == OP_SUBTRACT_SIXTEEN_BIT_IMM);
    if (mode == 4)
      put(OP_PREFIX_Y);
    put(base + OFS[mode]);
    case (mode)
      0: ea = pc_w;
      1: ea = 16'h0050;
      2: ea = 16'h1234;
      3: ea = 16'h0060;
      default: ea = 16'h0070;
    endcase
    if (mode == 2)
      put(ea[15:8]);
    if (mode != 0)
      put(ea[7:0]);
    trap_memory_model_inst.mem[ea] = wide ? val[15:8] : val[7:0];
    if (wide)
      trap_memory_model_inst.mem[ea + 16'h0001] = val[7:0];
    if (mode == 0)
      pc_w = pc_w + (wide ? 16'h0002 : 16'h0001);
    if (wide)
      r = sub_calc({exp_a, exp_b}, val, 1'b1, exp_cc);
    else
      r = sub_calc(16'(base == OP_SUBTRACT_FROM_A_IMM ? exp_a : exp_b), val, 1'b0,
        exp_cc);
    if (wide || base == OP_SUBTRACT_FROM_A_IMM)
      exp_a = wide ? r[23:16] : r[15:8];
    if (wide || base == OP_SUBTRACT_FROM_B_IMM)
      exp_b = r[15:8];
    exp_cc = r[7:0];
  endtask

  task automatic tab();
    put(OP_TAB);
    exp_b = exp_a;
    exp_cc[CC_N] = exp_a[7];
    exp_cc[CC_Z] = (exp_a == 8'h00);
    exp_cc[CC_V] = 1'b0;
  endtask

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0]  m1;
    logic [7:0]  m2;
    logic [7:0]  stk [0:8];
    logic [15:0] hold;
    nrst_i = 1'b0;
    ce_i = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(32'h0F4F));
    // kinds and modes cycle so every mode meets every kind twice
    for (int i = 0; i < 30; i++)
    begin
      m1 = (i < 4) ? CORNER[i] : 8'($urandom);
      m2 = (i < 4) ? CORNER[3 - i] : 8'($urandom);
      if (i == 4)
        m2 = 8'(-m1);
      start_case();
      emit(OP_SUBTRACT_FROM_A_IMM, 0, 16'(m1));
      if (i % 3 == 0)
        emit(OP_SUBTRACT_FROM_A_IMM, i % 5, 16'(m2));
      else
        tab();
      if (i % 3 == 1)
        emit(OP_SUBTRACT_FROM_B_IMM, i % 5, 16'(m2));
      if (i % 3 == 2)
      begin
        emit(OP_SUBTRACT_FROM_A_IMM, 0, 16'(m2));
        emit(OP_SUBTRACT_SIXTEEN_BIT_IMM, i % 5, 16'($urandom));
      end
      go(30);
      check(16'(acc_a_o), 16'(exp_a));
      check(16'(acc_b_o), 16'(exp_b));
      check(16'(ccr_o), 16'(exp_cc));
    end
    // trap with the mask already set by reset
    start_case();
    emit(OP_SUBTRACT_FROM_A_IMM, 0, 16'($urandom));
    tab();
    put(OP_TRAP);
    trap_memory_model_inst.mem[TRAP_VECTOR] = 8'h20;
    trap_memory_model_inst.mem[TRAP_VECTOR + 16'h0001] = 8'h00;
    stk = '{pc_w[7:0], pc_w[15:8], 8'h00, 8'h00, 8'h00, 8'h00,
      exp_a, exp_b, exp_cc};
    exp_cc[CC_I] = 1'b1;
    go(24);
    for (int k = 0; k < 9; k++)
      check(16'(trap_memory_model_inst.mem[SP_RESET - 16'(k)]),
        16'(stk[k]));
    check(sp_o, SP_RESET - 16'h0009);
    check(16'(ccr_o), 16'(exp_cc));
    check(16'(pc_o[15:8]), 16'h0020);
    check(16'(acc_b_o), 16'(exp_b));
    hold = pc_o;
    ce_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    check(pc_o, hold);
    ce_i = 1'b1;
    go(4);
    wrap_up();
  end
endmodule
